/* hdl/apcc_device.sv */
// module: converter control end, load sequence, modes and config registers
// What this block does
// [R1] reset enters load mode, internal clock on
// [R2] copy trim and cal images, 188 pulses
// [R3] no external clock: wakeup mode, threshold 2^14
// [R4] external clock: single measure with defaults
// [R5] selected gain factor loads as zeros
// [R6] host restores calibration factor after reset
// [R7] calibration and trim writable after loading
// [R8] mux switches follow config registers
// [R9] value trim steps reference 5.1 mV
// [R10] tempco trim takes 0..31 immediately
// [R11] host trims tempco before value
// [R12] current level: 31 steps of 8 uA
// [R13] current routes to battery, ref, sensor
// [R14] shunt test sources; open terminal sets overflow
// [R15] temperature sensor uses gain 6
// [R16] factory register holds 11-bit 23 degC reading
// [R17] host computes temperature from stored reference
// [R18] rate = clock / (osr * chop * avg)
// [R19] dual mode: no averaging, alternate channels
// [R20] ready low when new result available
// [R21] mode commands ignored until loading done
`timescale 1ns/1ps
module apcc_device #(
  parameter logic [15:0] TRIM_IMAGE = 16'h0000,
  parameter logic [15:0] CAL_IMAGE = 16'h0000,
  parameter int RESULT_PERIOD = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  apcc_link_if.device link,
  input wire logic [15:0] adc_sample,
  input wire logic adc_saturated,
  output logic int_osc_en,
  output logic [3:0] mode_out,
  output logic [15:0] mux_switches,
  output logic [4:0] current_level,
  output logic [3:0] current_route_en,
  output logic [1:0] shunt_src_en,
  output logic [1:0] pga_gain,
  output logic [5:0] ref_value_trim,
  output logic [4:0] ref_tempco_trim,
  output logic [4:0] current_trim,
  output logic [13:0] rate_divisor,
  output logic active_channel_b
);
  // load sequencer states, gray along load, decide, run
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_DECIDE = 2'b01,
    ST_RUN = 2'b11
  } apcc_dev_st_e;
  apcc_dev_st_e state_q;
  logic [7:0] pulse_cnt_q; // load pulses issued
  logic pulse_phase_q; // toggles each clock during load
  logic [3:0] mode_q; // current operating mode
  logic [15:0] chan_a_q; // channel a configuration
  logic [15:0] chan_b_q; // channel b configuration
  logic [15:0] general_q; // general configuration
  logic [15:0] threshold_q; // wake-up threshold
  logic [15:0] trim_q; // working trim register
  logic [15:0] cal_q; // working calibration register
  logic [15:0] gain_factor_q; // selected gain factor in use
  logic [16:0] result_q; // result, bit 16 overflow
  logic [13:0] rate_cnt_q; // result cadence counter
  logic chan_b_q_sel; // dual mode channel select
  logic ack_q;
  logic [16:0] rdata_q;
  logic ready_n_q;
  logic [15:0] active_cfg;
  logic wr_hit;
  logic [13:0] divisor;

  assign wr_hit = link.req && link.wr;
  assign active_cfg = chan_b_q_sel ? chan_b_q : chan_a_q;

  // sampling-rate divisor from the active configuration
  always_comb
  begin
    logic [13:0] osr;
    logic [13:0] chop;
    logic [13:0] avg;
    osr = active_cfg[apcc_pkg::CFG_OSR_BIT] ? 14'h0080 : 14'h0040;
    chop = active_cfg[apcc_pkg::CFG_CHOP_BIT] ? 14'h0008 : 14'h0004;
    avg = 14'h0001 << active_cfg[apcc_pkg::CFG_AVG_LSB +: 2];
    if (mode_q == apcc_pkg::MODE_DUAL_MEASURE)
    begin
      avg = 14'h0001; // [R19]
    end
    divisor = 14'((osr * chop) * avg); // [R18]
  end

  // load sequencer and post-reset mode choice
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_LOAD; // [R1]
      mode_q <= apcc_pkg::MODE_POWER_ON_LOAD; // [R1]
      pulse_cnt_q <= 8'h00;
      pulse_phase_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_LOAD:
        begin
          pulse_phase_q <= ~pulse_phase_q;
          if (pulse_phase_q)
          begin
            pulse_cnt_q <= pulse_cnt_q + 8'h01;
            if (pulse_cnt_q == 8'(apcc_pkg::LOAD_PULSES - 1)) // [R2]
            begin
              state_q <= ST_DECIDE;
            end
          end
        end
        ST_DECIDE:
        begin
          state_q <= ST_RUN;
          if (link.ext_clk_present)
          begin
            mode_q <= apcc_pkg::MODE_SINGLE_MEASURE; // [R4]
          end
          else
          begin
            mode_q <= apcc_pkg::MODE_WAKEUP; // [R3]
          end
        end
        ST_RUN:
        begin
          if (wr_hit && link.addr == apcc_pkg::ADDR_MODE) // [R21]
          begin
            mode_q <= link.wdata[3:0];
          end
        end
        default:
        begin
          state_q <= ST_LOAD;
        end
      endcase
    end
  end

  // configuration registers written over the link
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_a_q <= apcc_pkg::CHAN_A_RST; // [R4]
      chan_b_q <= apcc_pkg::CHAN_B_RST;
      general_q <= apcc_pkg::GENERAL_RST;
      threshold_q <= apcc_pkg::THRESHOLD_RST; // [R3]
    end
    else if (wr_hit)
    begin
      if (link.addr == apcc_pkg::ADDR_CHAN_A)
      begin
        chan_a_q <= link.wdata; // [R8]
      end
      else if (link.addr == apcc_pkg::ADDR_CHAN_B)
      begin
        chan_b_q <= link.wdata; // [R8]
      end
      else if (link.addr == apcc_pkg::ADDR_GENERAL)
      begin
        general_q <= link.wdata; // [R8]
      end
      else if (link.addr == apcc_pkg::ADDR_THRESHOLD)
      begin
        threshold_q <= link.wdata;
      end
    end
  end

  // trim and calibration: image copy at load, host writes afterwards
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trim_q <= 16'h0000;
      cal_q <= 16'h0000;
      gain_factor_q <= 16'h0000; // [R5]
    end
    else if (state_q == ST_LOAD)
    begin
      trim_q <= TRIM_IMAGE; // [R2]
      cal_q <= CAL_IMAGE; // [R2]
    end
    else if (state_q == ST_RUN && wr_hit)
    begin
      if (link.addr == apcc_pkg::ADDR_TRIM)
      begin
        trim_q <= link.wdata; // [R7] [R10]
      end
      else if (link.addr == apcc_pkg::ADDR_CAL)
      begin
        cal_q <= link.wdata; // [R7]
        gain_factor_q <= link.wdata; // [R6]
      end
    end
  end

  // result cadence, channel alternation, ready pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rate_cnt_q <= 14'h0000;
      result_q <= 17'h0_0000;
      chan_b_q_sel <= 1'b0;
      ready_n_q <= 1'b1;
    end
    else if (state_q == ST_LOAD)
    begin
      ready_n_q <= pulse_phase_q; // [R2]
    end
    else if (state_q == ST_RUN && mode_q != apcc_pkg::MODE_WAKEUP)
    begin
      if (rate_cnt_q >= divisor - 14'h0001)
      begin
        rate_cnt_q <= 14'h0000;
        ready_n_q <= 1'b0; // [R20]
        // zero factor gives zero result until recalibrated
        result_q <= {adc_saturated, // [R14]
          (gain_factor_q == 16'h0000) ? 16'h0000 : adc_sample}; // [R5]
        if (mode_q == apcc_pkg::MODE_DUAL_MEASURE)
        begin
          chan_b_q_sel <= ~chan_b_q_sel; // [R19]
        end
        else
        begin
          chan_b_q_sel <= 1'b0;
        end
      end
      else
      begin
        rate_cnt_q <= rate_cnt_q + 14'h0001;
        ready_n_q <= 1'b1;
      end
    end
    else
    begin
      ready_n_q <= 1'b1;
    end
  end

  // register read and ack, one cycle after request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_q <= 1'b0;
      rdata_q <= 17'h0_0000;
    end
    else
    begin
      ack_q <= link.req;
      if (link.req && !link.wr)
      begin
        if (link.addr == apcc_pkg::ADDR_MODE)
        begin
          rdata_q <= {13'h0000, mode_q};
        end
        else if (link.addr == apcc_pkg::ADDR_CHAN_A)
        begin
          rdata_q <= {1'b0, chan_a_q};
        end
        else if (link.addr == apcc_pkg::ADDR_CHAN_B)
        begin
          rdata_q <= {1'b0, chan_b_q};
        end
        else if (link.addr == apcc_pkg::ADDR_GENERAL)
        begin
          rdata_q <= {1'b0, general_q};
        end
        else if (link.addr == apcc_pkg::ADDR_THRESHOLD)
        begin
          rdata_q <= {1'b0, threshold_q};
        end
        else if (link.addr == apcc_pkg::ADDR_CAL)
        begin
          rdata_q <= {1'b0, cal_q};
        end
        else if (link.addr == apcc_pkg::ADDR_TRIM)
        begin
          rdata_q <= {1'b0, trim_q};
        end
        else if (link.addr == apcc_pkg::ADDR_FACTORY)
        begin
          rdata_q <= {6'h00, apcc_pkg::FACTORY_TEMP_RST}; // [R16]
        end
        else if (link.addr == apcc_pkg::ADDR_RESULT)
        begin
          rdata_q <= result_q;
        end
        else
        begin
          rdata_q <= 17'h0_0000;
        end
      end
    end
  end

  // analog control outputs, all registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_osc_en <= 1'b1; // [R1]
      mode_out <= 4'h0;
      mux_switches <= 16'h0000;
      current_level <= 5'h00;
      current_route_en <= 4'h0;
      shunt_src_en <= 2'h0;
      pga_gain <= apcc_pkg::GAIN_6;
      ref_value_trim <= 6'h00;
      ref_tempco_trim <= 5'h00;
      current_trim <= 5'h00;
      rate_divisor <= 14'h0000;
      active_channel_b <= 1'b0;
    end
    else
    begin
      int_osc_en <= (state_q != ST_RUN) || !link.ext_clk_present;
      mode_out <= mode_q;
      mux_switches <= {general_q[apcc_pkg::GEN_REPEAT_LSB +: 4],
        chan_b_q[apcc_pkg::CFG_MUX_LSB +: 4],
        chan_a_q[apcc_pkg::CFG_MUX_LSB +: 4],
        active_cfg[apcc_pkg::CFG_MUX_LSB +: 4]}; // [R8]
      current_level <= general_q[apcc_pkg::GEN_CUR_LSB +: 5]; // [R12]
      current_route_en <= 4'h1 <<
        general_q[apcc_pkg::GEN_ROUTE_LSB +: 2]; // [R13]
      shunt_src_en <= {general_q[apcc_pkg::GEN_SHUNT_HI_BIT],
        general_q[apcc_pkg::GEN_SHUNT_LO_BIT]}; // [R14]
      pga_gain <= active_cfg[apcc_pkg::CFG_TSENS_BIT] ? apcc_pkg::GAIN_6
        : active_cfg[apcc_pkg::CFG_GAIN_LSB +: 2]; // [R15]
      ref_value_trim <= trim_q[apcc_pkg::TRIM_VALUE_LSB +: 6]; // [R9]
      ref_tempco_trim <= trim_q[apcc_pkg::TRIM_TEMPCO_LSB +: 5]; // [R10]
      current_trim <= trim_q[apcc_pkg::TRIM_CUR_LSB +: 5];
      rate_divisor <= divisor; // [R18]
      active_channel_b <= chan_b_q_sel;
    end
  end

  assign link.ack = ack_q;
  assign link.rdata = rdata_q;
  assign link.ready_irq_n = ready_n_q;
endmodule

/* hdl/apcc_host.sv */
// module: host controller end, apb slave driving the register link
`timescale 1ns/1ps
module apcc_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  apcc_link_if.host link
);
  logic [3:0] cmd_addr_q; // target device address
  logic cmd_read_q; // 1 read command
  logic [15:0] wdata_q; // data to write
  logic [16:0] rdata_q; // last read data
  logic busy_q; // transfer outstanding
  logic req_q;
  logic ready_seen_q; // sticky ready low seen
  logic access;
  assign access = psel && penable;

  // apb writes and link request, one request pulse per go
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_addr_q <= 4'h0;
      cmd_read_q <= 1'b0;
      wdata_q <= 16'h0000;
      busy_q <= 1'b0;
      req_q <= 1'b0;
    end
    else
    begin
      req_q <= 1'b0;
      if (access && pwrite && paddr == apcc_pkg::HOST_WDATA)
      begin
        wdata_q <= pwdata[15:0];
      end
      else if (access && pwrite && paddr == apcc_pkg::HOST_CMD)
      begin
        cmd_addr_q <= pwdata[3:0];
        cmd_read_q <= pwdata[apcc_pkg::CMD_READ_BIT];
        if (pwdata[apcc_pkg::CMD_GO_BIT] && !busy_q)
        begin
          busy_q <= 1'b1;
          req_q <= 1'b1;
        end
      end
      if (link.ack)
      begin
        busy_q <= 1'b0;
      end
    end
  end

  // capture read data and ready events, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 17'h0_0000;
      ready_seen_q <= 1'b0;
    end
    else
    begin
      if (link.ack && cmd_read_q)
      begin
        rdata_q <= link.rdata;
      end
      if (!link.ready_irq_n)
      begin
        ready_seen_q <= 1'b1;
      end
      else if (access && pwrite && paddr == apcc_pkg::HOST_STATUS
        && pwdata[1])
      begin
        ready_seen_q <= 1'b0;
      end
    end
  end

  // apb read data, single wait-free answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite)
      begin
        if (paddr == apcc_pkg::HOST_CMD)
        begin
          prdata <= {22'h00_0000, cmd_read_q, 5'h00, cmd_addr_q};
        end
        else if (paddr == apcc_pkg::HOST_WDATA)
        begin
          prdata <= {16'h0000, wdata_q};
        end
        else if (paddr == apcc_pkg::HOST_RDATA)
        begin
          prdata <= {15'h0000, rdata_q};
        end
        else if (paddr == apcc_pkg::HOST_STATUS)
        begin
          prdata <= {29'h0000_0000, !link.ready_irq_n, ready_seen_q, busy_q};
        end
        else
        begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      end
    end
  end

  assign link.req = req_q;
  assign link.wr = !cmd_read_q;
  assign link.addr = cmd_addr_q;
  assign link.wdata = wdata_q;
endmodule

/* hdl/apcc_link_if.sv */
// interface: register link between host controller and converter control
`timescale 1ns/1ps
interface apcc_link_if;
  logic req; // host request strobe
  logic wr; // 1 write, 0 read
  logic [3:0] addr; // device register address
  logic [15:0] wdata; // write data
  logic ack; // device answer pulse
  logic [16:0] rdata; // read data
  logic ready_irq_n; // active low ready / load pacing
  logic ext_clk_present; // external clock detect level
  modport device (input req, input wr, input addr, input wdata,
    input ext_clk_present, output ack, output rdata, output ready_irq_n);
  modport host (output req, output wr, output addr, output wdata,
    input ack, input rdata, input ready_irq_n);
endinterface

/* hdl/apcc_pkg.sv */
// package: shared constants and types for the converter control link
package apcc_pkg;
  // operating modes as carried in the mode register
  typedef enum logic [3:0] {
    MODE_POWER_ON_LOAD = 4'h0,
    MODE_SINGLE_MEASURE = 4'h1,
    MODE_DUAL_MEASURE = 4'h2,
    MODE_WAKEUP = 4'h3,
    MODE_INT_CLOCK_SINGLE = 4'h7
  } apcc_mode_e;
  // device register addresses on the register link
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_CHAN_A = 4'h1;
  localparam logic [3:0] ADDR_CHAN_B = 4'h2;
  localparam logic [3:0] ADDR_GENERAL = 4'h3;
  localparam logic [3:0] ADDR_THRESHOLD = 4'h4;
  localparam logic [3:0] ADDR_CAL = 4'h5;
  localparam logic [3:0] ADDR_TRIM = 4'h6;
  localparam logic [3:0] ADDR_FACTORY = 4'h7;
  localparam logic [3:0] ADDR_RESULT = 4'h8;
  // load sequence pacing
  localparam int LOAD_PULSES = 188;
  // default threshold is two to the power fourteen
  localparam logic [15:0] THRESHOLD_RST = 16'h4000;
  // default channel a config: gain 100, osr 64, chop 4, avg 1
  localparam logic [1:0] GAIN_100 = 2'h3;
  localparam logic [1:0] GAIN_6 = 2'h0;
  localparam logic [15:0] CHAN_A_RST = 16'h0003;
  localparam logic [15:0] CHAN_B_RST = 16'h0000;
  localparam logic [15:0] GENERAL_RST = 16'h0000;
  // channel config fields
  localparam int CFG_GAIN_LSB = 0;
  localparam int CFG_OSR_BIT = 2;
  localparam int CFG_CHOP_BIT = 3;
  localparam int CFG_AVG_LSB = 4;
  localparam int CFG_MUX_LSB = 8;
  localparam int CFG_TSENS_BIT = 12;
  // general config fields
  localparam int GEN_CUR_LSB = 0;
  localparam int GEN_ROUTE_LSB = 5;
  localparam int GEN_SHUNT_LO_BIT = 7;
  localparam int GEN_SHUNT_HI_BIT = 8;
  localparam int GEN_REPEAT_LSB = 9;
  // trim register fields
  localparam int TRIM_VALUE_LSB = 0;
  localparam int TRIM_TEMPCO_LSB = 6;
  localparam int TRIM_CUR_LSB = 11;
  // current route codes
  localparam logic [1:0] ROUTE_OFF = 2'h0;
  localparam logic [1:0] ROUTE_BATTERY = 2'h1;
  localparam logic [1:0] ROUTE_EXT_TEMP_REF = 2'h2;
  localparam logic [1:0] ROUTE_EXT_TEMP_SENSOR = 2'h3;
  // temperature reference at 23 degC, arbitrary factory value
  localparam logic [10:0] FACTORY_TEMP_RST = 11'h59c;
  // apb register offsets of the host controller
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_WDATA = 8'h04;
  localparam logic [7:0] HOST_RDATA = 8'h08;
  localparam logic [7:0] HOST_STATUS = 8'h0c;
  // host command bit positions
  localparam int CMD_GO_BIT = 8;
  localparam int CMD_READ_BIT = 9;
endpackage

/* test/adc_por_calibration_control_test.sv */
// testbench: both ends joined, driven over apb
`timescale 1ns/1ps
module adc_por_calibration_control_test;
  localparam logic [15:0] TRIM_IMG = 16'h1234; // arbitrary trim image
  localparam logic [15:0] CAL_IMG = 16'h5a5a; // arbitrary cal image
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ext, adc_sat, osc_en, act_b;
  logic [15:0] adc, mux;
  logic [3:0] mode_out, route_en;
  logic [4:0] cur_lvl, tc_trim, cur_trim;
  logic [1:0] shunt_en, gain;
  logic [5:0] val_trim;
  logic [13:0] div;
  int err_count, samples_checked, cyc;
  apcc_link_if link ();
  assign link.ext_clk_present = ext;
  apcc_device #(.TRIM_IMAGE(TRIM_IMG), .CAL_IMAGE(CAL_IMG)) apcc_device_i (
    .pclk(pclk), .presetn(presetn), .link(link), .adc_sample(adc),
    .adc_saturated(adc_sat), .int_osc_en(osc_en), .mode_out(mode_out),
    .mux_switches(mux), .current_level(cur_lvl),
    .current_route_en(route_en), .shunt_src_en(shunt_en), .pga_gain(gain),
    .ref_value_trim(val_trim), .ref_tempco_trim(tc_trim),
    .current_trim(cur_trim), .rate_divisor(div), .active_channel_b(act_b));
  apcc_host apcc_host_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  apcc_link_asserts apcc_link_asserts_i (
    .pclk(pclk), .presetn(presetn), .req(link.req), .wr(link.wr),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
    .rdata(link.rdata), .ready_irq_n(link.ready_irq_n),
    .ext_clk_present(link.ext_clk_present));
  // clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // compare one value, count and report
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so no strobe is driven twice in one step
    @(posedge pclk);
  endtask
  // one device register access through the host
  task dev(input logic rdop, input logic [3:0] a, input logic [15:0] d);
    apb(1'b1, apcc_pkg::HOST_WDATA, {16'h0000, d});
    apb(1'b1, apcc_pkg::HOST_CMD, {22'h00_0000, rdop, 1'b1, 4'h0, a});
    while (link.ack !== 1'b1)
      @(posedge pclk);
    repeat (2) @(posedge pclk);
    if (rdop)
      apb(1'b0, apcc_pkg::HOST_RDATA, 32'h0000_0000);
  endtask
  // wait for one result pulse to pass
  task wait_rdy;
    while (link.ready_irq_n !== 1'b0)
      @(posedge pclk);
    @(posedge pclk);
  endtask
  // reset with a chosen clock detect level
  task do_reset(input logic x);
    presetn <= 1'b0;
    ext <= x;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("mode_load", apcc_pkg::MODE_POWER_ON_LOAD, mode_out);
    chk("osc_en", 1, osc_en);
  endtask
  // no clock: wake-up, images copied, early mode write dropped
  task t_wakeup;
    do_reset(1'b0);
    dev(1'b0, apcc_pkg::ADDR_MODE, 16'h0001);
    repeat (380) @(posedge pclk);
    chk("mode_wu", apcc_pkg::MODE_WAKEUP, mode_out);
    chk("osc_wu", 1, osc_en);
    dev(1'b1, apcc_pkg::ADDR_THRESHOLD, 16'h0000);
    chk("thresh", apcc_pkg::THRESHOLD_RST, rd);
    dev(1'b1, apcc_pkg::ADDR_TRIM, 16'h0000);
    chk("trim_rd", TRIM_IMG, rd);
    chk("val_trim", TRIM_IMG[5:0], val_trim);
    chk("tc_trim", TRIM_IMG[10:6], tc_trim);
    dev(1'b1, apcc_pkg::ADDR_CAL, 16'h0000);
    chk("cal_rd", CAL_IMG, rd);
    dev(1'b1, apcc_pkg::ADDR_FACTORY, 16'h0000);
    chk("factory", apcc_pkg::FACTORY_TEMP_RST, rd);
    // load pulses left the sticky flag set, none since in wake-up
    apb(1'b0, apcc_pkg::HOST_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_0002, rd);
    apb(1'b1, apcc_pkg::HOST_STATUS, 32'h0000_0002);
    apb(1'b0, apcc_pkg::HOST_STATUS, 32'h0000_0000);
    chk("status_clr", 32'h0000_0000, rd);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", 1, e);
  endtask
  // clock present: single measure, zero result until cal rewritten
  task t_single;
    do_reset(1'b1);
    repeat (380) @(posedge pclk);
    chk("mode_ss", apcc_pkg::MODE_SINGLE_MEASURE, mode_out);
    chk("gain", apcc_pkg::GAIN_100, gain);
    chk("div", 14'h0100, div);
    wait_rdy();
    dev(1'b1, apcc_pkg::ADDR_RESULT, 16'h0000);
    chk("res_zero", 0, rd);
    dev(1'b0, apcc_pkg::ADDR_CAL, CAL_IMG);
    wait_rdy();
    wait_rdy();
    dev(1'b1, apcc_pkg::ADDR_RESULT, 16'h0000);
    chk("res_live", 1, {31'h0000_0000, |rd[15:0]});
  endtask
  // trim sweep, current routes, config fields, overflow
  task t_cfg;
    for (int i = 0; i < 32; i++)
    begin
      dev(1'b0, apcc_pkg::ADDR_TRIM, {5'h03, 5'(i), 6'h00});
      chk("tc_sweep", i, tc_trim);
    end
    // value trim only after the tempco sweep
    dev(1'b0, apcc_pkg::ADDR_TRIM, {5'h03, 5'h1f, 6'h2a});
    chk("tc_keep", 5'h1f, tc_trim);
    chk("val_step", 6'h2a, val_trim);
    chk("cur_trim", 5'h03, cur_trim);
    for (int r = 0; r < 4; r++)
    begin
      dev(1'b0, apcc_pkg::ADDR_GENERAL, {7'h00, 2'b01, 2'(r), 5'h1f});
      chk("route", 4'h1 << r, route_en);
      chk("cur_lvl", 5'h1f, cur_lvl);
      chk("shunt", 2'b01, shunt_en);
    end
    // overflow input raised before the config change
    adc_sat <= 1'b1;
    dev(1'b0, apcc_pkg::ADDR_CHAN_A, 16'h152e);
    chk("gain_ts", apcc_pkg::GAIN_6, gain);
    chk("div_a", 14'h1000, div);
    chk("mux", 16'h0055, mux);
    wait_rdy();
    dev(1'b1, apcc_pkg::ADDR_RESULT, 16'h0000);
    chk("ovf", 1, rd[16]);
    adc_sat <= 1'b0;
  endtask
  // dual mode: averaging off, channels alternate
  task t_dual;
    int n; // cycles spent on channel b
    n = 0;
    // channel b: osr 64, chop 4, averaging field ignored in dual
    dev(1'b0, apcc_pkg::ADDR_CHAN_B, 16'h0020);
    dev(1'b0, apcc_pkg::ADDR_MODE, 16'h0002);
    chk("mode_dm", apcc_pkg::MODE_DUAL_MEASURE, mode_out);
    while (act_b !== 1'b1)
      @(posedge pclk);
    chk("div_b", 14'h0100, div);
    // one full channel b phase lasts its own divisor
    while (act_b !== 1'b0)
    begin
      @(posedge pclk);
      n++;
    end
    chk("alt", 14'h0100, n);
    chk("div_dm", 14'h0400, div);
  endtask
  // report and stop
  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      print_verdict();
    end
  end
  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ext = 1'b0;
    adc = 16'h1234;
    adc_sat = 1'b0;
    @(posedge pclk);
    t_wakeup();
    t_single();
    t_cfg();
    t_dual();
    print_verdict();
  end
endmodule

/* test/apcc_link_asserts.sv */
// checker: link timing and load pacing between the two ends
`timescale 1ns/1ps
module apcc_link_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic wr,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [16:0] rdata,
  input wire logic ready_irq_n,
  input wire logic ext_clk_present
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [9:0] lc_q; // cycles since reset release
  logic [8:0] falls_q; // ready falls seen during load
  logic rdy_q; // ready level one cycle back
  logic ext_q; // clock detect near load end
  logic mw_q; // a mode write after load
  // saturating cycle counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lc_q <= 10'h000;
    else if (lc_q != 10'h3ff)
      lc_q <= lc_q + 10'h001;
  end
  // count load pulses on the ready pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      falls_q <= 9'h000;
      rdy_q <= 1'b1;
    end
    else
    begin
      rdy_q <= ready_irq_n;
      if (lc_q < 10'h17a && rdy_q && !ready_irq_n)
        falls_q <= falls_q + 9'h001;
    end
  end
  // remember clock detect and later mode writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_q <= 1'b0;
      mw_q <= 1'b0;
    end
    else
    begin
      if (lc_q == 10'h12c)
        ext_q <= ext_clk_present;
      if (req && wr && addr == apcc_pkg::ADDR_MODE && lc_q > 10'h17c)
        mw_q <= 1'b1;
    end
  end
  property p_ack_follows;
    req |=> ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("ack missing after request");
  property p_ack_cause;
    ack |-> $past(req);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_req_pulse;
    req |=> !req;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("request longer than one cycle");
  property p_ready_pulse;
    !ready_irq_n |=> ready_irq_n;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready low longer than one cycle");
  property p_load_pulses;
    lc_q == 10'h17c |-> falls_q == 9'h0bc;
  endproperty
  a_load_pulses: assert property (p_load_pulses)
    else $error("wrong count of load pulses");
  property p_wakeup_quiet;
    (lc_q > 10'h17c && !ext_q && !mw_q) |-> ready_irq_n;
  endproperty
  a_wakeup_quiet: assert property (p_wakeup_quiet)
    else $error("ready pulse while waiting in wake-up");
  property p_single_results;
    (lc_q == 10'h17d && ext_q) |-> ##[1:600] !ready_irq_n;
  endproperty
  a_single_results: assert property (p_single_results)
    else $error("no result in single measurement");
  property p_rdata_on_read;
    $changed(rdata) |-> (ack && !wr);
  endproperty
  a_rdata_on_read: assert property (p_rdata_on_read)
    else $error("read data changed outside a read");
endmodule
